// ### fphp_sync.sv
/*
  Holds the shared package for the parallel host port and a small
  two-stage synchroniser used on every pin that enters the port.
  Assumes a single clock domain and a synchronous active-high reset.
*/
package fphp_pkg;

  // Pin and bus widths
  localparam int unsigned DATA_W           = 8;
  localparam int unsigned ADDR_W           = 5;

  // Clock and reset pulse timing
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned RESET_MIN_NS     = 1000;
  localparam int unsigned RESET_MIN_CYC    =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Values after reset
  localparam logic [DATA_W-1:0] DATA_RST   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST   = 5'h00;
  localparam logic              PIN_IDLE   = 1'b1;
  localparam logic              STYLE_RST  = 1'b1;

  // Bus style strap values
  localparam logic              STYLE_SPLIT = 1'b1;
  localparam logic              STYLE_DIR   = 1'b0;

  // Port sequencer states
  typedef enum logic [2:0] {
    FPHP_IDLE  = 3'b001,
    FPHP_READ  = 3'b010,
    FPHP_WRITE = 3'b100
  } fphp_state_t;

endpackage : fphp_pkg

module fphp_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;        // First stage, read only by stage two
  logic [WIDTH-1:0] next_stage1;   // Next first stage
  logic [WIDTH-1:0] next_sync_out; // Next second stage

  // Next values: shift one stage per edge
  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
    if (rst) begin
      next_stage1   = RESET_VAL;
      next_sync_out = RESET_VAL;
    end
  end

  // Registers only
  always_ff @(posedge ref_clk) begin
    stage1   <= next_stage1;
    sync_out <= next_sync_out;
  end

endmodule : fphp_sync

// ### fphp_top.sv
/*
  Holds the non-multiplexed 8-bit parallel host port: pin sequencing
  for both bus styles, tri-state data bus, open-drain interrupt line
  and the reset pin. Assumes the register file on the user side
  answers reg_rdata combinationally from reg_addr, and that the
  testbench resolves the data and interrupt wires from the enables.
*/
// Function
// - Strap high: split strobes; low: direction line
// - Direction style: shared strobe is data strobe
// - Split style: shared strobe is read strobe
// - Strobes ignored while chip select high
// - Deselected: port idle, data bus released
// - Interrupt pending pulls open-drain line low
// - Interrupt line independent of chip select
// - Eight-bit tri-state data bus, bit0 LSB
// - Five address inputs, lowest is LSB
// - Direction style: high read, low write
// - Split style: direction pin is write strobe
module fphp_top (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic                         reset_pin_n,
  input  wire logic                         bus_style_select,
  input  wire logic                         chip_select_n,
  input  wire logic                         data_or_read_strobe_n,
  input  wire logic                         direction_or_write_n,
  input  wire logic [fphp_pkg::ADDR_W-1:0]  host_address_lines,
  input  wire logic [fphp_pkg::DATA_W-1:0]  host_data_bus_in,
  output logic      [fphp_pkg::DATA_W-1:0]  host_data_bus_out,
  output logic                              host_data_bus_oe,
  output logic                              irq_out,
  output logic                              irq_oe,
  output logic                              device_reset,
  output logic      [fphp_pkg::ADDR_W-1:0]  reg_addr,
  output logic      [fphp_pkg::DATA_W-1:0]  reg_wdata,
  output logic                              reg_write,
  output logic                              reg_read,
  input  wire logic [fphp_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                         irq_pending
);

  // Synchronised pin levels
  // All of them lag their pins by two edges
  logic                        reset_pin_s;   // Reset pin after two flops
  logic                        style_s;       // Bus style strap
  logic                        cs_n_s;        // Chip select
  logic                        strb_n_s;      // Shared data/read strobe
  logic                        dir_wr_n_s;    // Direction or write strobe
  logic [fphp_pkg::ADDR_W-1:0] addr_s;        // Address lines
  logic [fphp_pkg::DATA_W-1:0] data_s;        // Write data lines

  // Decoded access qualifiers
  logic                        port_rst;      // Any reset source
  logic                        rd_q;          // Read access in progress
  logic                        wr_q;          // Write access in progress

  // Sequencer state and next values
  // State is one-hot; the next_ values come only from the comb blocks
  fphp_pkg::fphp_state_t       state;
  fphp_pkg::fphp_state_t       next_state;
  logic [fphp_pkg::DATA_W-1:0] next_data_out;
  logic                        next_data_oe;
  logic [fphp_pkg::ADDR_W-1:0] next_reg_addr;
  logic [fphp_pkg::DATA_W-1:0] next_reg_wdata;
  logic                        next_reg_write;
  logic                        next_reg_read;
  logic                        next_irq_oe;
  logic                        next_device_reset;
  logic                        next_irq_out;  // Open-drain driven level

  // Reset pin and strap through two flops
  fphp_sync #(
    .WIDTH     (2),
    .RESET_VAL ({fphp_pkg::PIN_IDLE, fphp_pkg::STYLE_RST})
  ) u_sync_ctl (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({reset_pin_n, bus_style_select}),
    .sync_out ({reset_pin_s, style_s})
  );

  // Strobes and chip select; idle high so reset reads as no access
  fphp_sync #(
    .WIDTH     (3),
    .RESET_VAL ({3{fphp_pkg::PIN_IDLE}})
  ) u_sync_strb (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({chip_select_n, data_or_read_strobe_n, direction_or_write_n}),
    .sync_out ({cs_n_s, strb_n_s, dir_wr_n_s})
  );

  // Address and data are stable while a strobe is low, so two flops
  // are enough; they settle no later than the synchronised strobe is seen
  fphp_sync #(
    .WIDTH     (fphp_pkg::ADDR_W + fphp_pkg::DATA_W),
    .RESET_VAL ({fphp_pkg::ADDR_RST, fphp_pkg::DATA_RST})
  ) u_sync_bus (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({host_address_lines, host_data_bus_in}),
    .sync_out ({addr_s, data_s})
  );

  // Either the local reset or the synchronised reset pin;
  // the pin clears the sequencer as well, not only the outputs
  assign port_rst = rst | ~reset_pin_s;

  // Access decode for both bus styles; chip select gates everything.
  // A qualifier seen here is already two edges behind the pins, so
  // address and data pass the same depth to stay aligned with it
  always_comb begin
    rd_q = 1'b0; // No access unless selected
    wr_q = 1'b0;
    if (!cs_n_s) begin
      if (style_s == fphp_pkg::STYLE_SPLIT) begin
        // Shared strobe reads, direction pin writes
        rd_q = ~strb_n_s;
        // A read strobe masks the write strobe: read wins
        wr_q = ~dir_wr_n_s & strb_n_s;
      end else begin
        // Data strobe qualifies, direction pin picks the way
        rd_q = ~strb_n_s & dir_wr_n_s;
        wr_q = ~strb_n_s & ~dir_wr_n_s;
      end
    end
  end

  // Sequencer next values. A strobe is acted on three edges after
  // its pin falls, and a write lands three edges after it rises.
  // Limitation: strobes shorter than one cycle can be missed, as
  // can gaps between accesses shorter than one cycle
  always_comb begin
    next_state        = state;
    next_data_out     = host_data_bus_out;
    next_reg_addr     = reg_addr;
    next_reg_wdata    = reg_wdata;
    next_reg_write    = 1'b0;
    next_reg_read     = 1'b0;
    next_irq_oe       = irq_pending;
    next_device_reset = ~reset_pin_s;
    unique case (state)
      fphp_pkg::FPHP_IDLE: begin
        // Read wins when both strobes appear at once
        if (rd_q) begin
          next_state    = fphp_pkg::FPHP_READ;
          next_reg_addr = addr_s;
          next_reg_read = 1'b1;
        end else if (wr_q) begin
          // Write waits for the trailing edge of its qualifier
          next_state     = fphp_pkg::FPHP_WRITE;
          next_reg_addr  = addr_s;
          next_reg_wdata = data_s;
        end
      end
      fphp_pkg::FPHP_READ: begin
        // Track register data while the read lasts
        next_data_out = reg_rdata;
        // Strobe end or deselect closes the read
        if (!rd_q) begin
          next_state = fphp_pkg::FPHP_IDLE;
        end
      end
      fphp_pkg::FPHP_WRITE: begin
        if (wr_q) begin
          // Keep the latest lines until the strobe ends
          next_reg_addr  = addr_s;
          next_reg_wdata = data_s;
        end else begin
          // Trailing edge commits the write
          next_state     = fphp_pkg::FPHP_IDLE;
          next_reg_write = 1'b1;
        end
      end
    endcase
    // Drive only in a live read; deselect releases at once
    // Released one edge after the qualifier drops, never later
    next_data_oe = (next_state == fphp_pkg::FPHP_READ) && rd_q;
    // Either reset source idles the port and frees both buses
    if (port_rst) begin
      next_state        = fphp_pkg::FPHP_IDLE;
      next_data_out     = fphp_pkg::DATA_RST;
      next_data_oe      = 1'b0;
      next_reg_addr     = fphp_pkg::ADDR_RST;
      next_reg_wdata    = fphp_pkg::DATA_RST;
      next_reg_write    = 1'b0;
      next_reg_read     = 1'b0;
      next_irq_oe       = 1'b0;
      next_device_reset = 1'b1;
    end
  end

  // Registers only
  always_ff @(posedge ref_clk) begin
    state             <= next_state;
    host_data_bus_out <= next_data_out;
    host_data_bus_oe  <= next_data_oe;
    reg_addr          <= next_reg_addr;
    reg_wdata         <= next_reg_wdata;
    reg_write         <= next_reg_write;
    reg_read          <= next_reg_read;
    irq_oe            <= next_irq_oe;
    device_reset      <= next_device_reset;
  end

  // Open drain: the driven level is always low, so the pin can
  // only pull the line down and the pull-up supplies the high level
  always_comb begin
    next_irq_out = 1'b0;
  end

  // Interrupt level register only
  always_ff @(posedge ref_clk) begin
    irq_out <= next_irq_out;
  end

endmodule : fphp_top

// ### fphp_monitor.sv
/* Checker for the host port pins of fphp_top.
   Sees only the top module's ports; bound at the foot of this file. */
module fphp_monitor (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       reset_pin_n,
  input wire logic       bus_style_select,
  input wire logic       chip_select_n,
  input wire logic       data_or_read_strobe_n,
  input wire logic       direction_or_write_n,
  input wire logic [7:0] host_data_bus_out,
  input wire logic       host_data_bus_oe,
  input wire logic       irq_out,
  input wire logic       irq_oe,
  input wire logic       device_reset,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq_pending
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Write strobe depends on the strap
  logic wr_idle;
  assign wr_idle = bus_style_select ? direction_or_write_n : data_or_read_strobe_n;

  a_desel_bus_idle: assert property (chip_select_n [*4] |-> !host_data_bus_oe)
    else $error("data bus driven while deselected");
  a_irq_follows: assert property (!rst |=> device_reset || irq_oe == $past(irq_pending))
    else $error("interrupt line not following pending");
  a_irq_drain_only: assert property (!irq_out)
    else $error("interrupt line driven high");
  a_read_cause: assert property (reg_read |->
    !$past(chip_select_n, 3) && !$past(data_or_read_strobe_n, 3))
    else $error("read without selected strobe");
  a_write_cause: assert property (reg_write |->
    $past(chip_select_n, 3) || $past(wr_idle, 3))
    else $error("write before qualifier ended");
  a_read_drives: assert property ($rose(host_data_bus_oe) |-> reg_read)
    else $error("bus driven without read");
  a_read_data: assert property (host_data_bus_oe && $past(host_data_bus_oe) |->
    host_data_bus_out == $past(reg_rdata))
    else $error("read data not tracking register");
  a_write_no_drive: assert property (reg_write |-> !host_data_bus_oe && !reg_read)
    else $error("write while driving bus");
  a_reset_follow: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3) |->
    device_reset == !$past(reset_pin_n, 3))
    else $error("device reset not following pin");
  c_read: cover property (reg_read);
  c_write: cover property (reg_write);
  c_irq: cover property (irq_oe);
endmodule : fphp_monitor

bind fphp_top fphp_monitor u_fphp_monitor (.*);

// ### fphp_host_model.sv
/* Host processor model on the parallel pins.
   Assumes the bench resolves the data wire and calls these tasks. */
module fphp_host_model (
  input  wire logic       ref_clk,
  input  wire logic       bus_style_select,
  input  wire logic [7:0] data_wire,
  output logic            reset_pin_n = 1'b1,
  output logic            chip_select_n = 1'b1,
  output logic            strobe_n = 1'b1,
  output logic            dir_n = 1'b1,
  output logic [4:0]      addr = 5'h00,
  output logic [7:0]      hdat = 8'h00,
  output logic            hen = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;

  // Reset pulse held for exactly the minimum width, RESET_MIN_CYC cycles
  task automatic pulse_reset();
    reset_pin_n <= 1'b0;
    repeat (fphp_pkg::RESET_MIN_CYC) @(posedge ref_clk);
    reset_pin_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
  endtask : pulse_reset

  // One access; strobes held 7 cycles so the synced pins settle
  task automatic access(input logic cs, input logic rd, input logic [4:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    chip_select_n <= cs;
    addr <= a;
    hdat <= d;
    hen <= !rd;
    if (bus_style_select) begin
      if (rd) begin
        strobe_n <= 1'b0;
      end else begin
        dir_n <= 1'b0;
      end
    end else begin
      dir_n <= rd;
      strobe_n <= 1'b0;
    end
    repeat (7) @(posedge ref_clk);
    q = data_wire;
    chip_select_n <= 1'b1;
    strobe_n <= 1'b1;
    dir_n <= 1'b1;
    hen <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask : access
endmodule : fphp_host_model

// ### fphp_top_tb.sv
/* Self-checking bench for fphp_top with a host model.
   Register file is a pattern of the address; released bus reads inverted. */
module fphp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       style = 1'b1;
  logic       irq_pending = 1'b0;
  wire        reset_pin_n, chip_select_n, strobe_n, dir_n, hen;
  wire  [4:0] addr;
  wire  [7:0] hdat;
  logic [7:0] out, wd, q, reg_wdata;
  logic [4:0] reg_addr, wa;
  logic       oe, irq_out, irq_oe, device_reset, reg_write, reg_read;
  wire  [7:0] data_wire = oe ? out : (hen ? hdat : ~hdat);
  wire        irq_line = irq_oe ? irq_out : 1'b1; // Pull-up
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         wn = 0;

  initial forever #10 ref_clk = ~ref_clk;

  fphp_top u_fphp_top (.ref_clk(ref_clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .bus_style_select(style), .chip_select_n(chip_select_n),
    .data_or_read_strobe_n(strobe_n), .direction_or_write_n(dir_n),
    .host_address_lines(addr), .host_data_bus_in(data_wire), .host_data_bus_out(out),
    .host_data_bus_oe(oe), .irq_out(irq_out), .irq_oe(irq_oe),
    .device_reset(device_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata({reg_addr, 3'h5}), .irq_pending(irq_pending));
  fphp_host_model u_fphp_host_model (.ref_clk(ref_clk), .bus_style_select(style),
    .data_wire(data_wire), .reset_pin_n(reset_pin_n), .chip_select_n(chip_select_n),
    .strobe_n(strobe_n), .dir_n(dir_n), .addr(addr), .hdat(hdat), .hen(hen));

  // Capture each committed write
  always @(posedge ref_clk) begin
    if (reg_write === 1'b1) begin
      wa <= reg_addr;
      wd <= reg_wdata;
      wn <= wn + 1;
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Write then read in one bus style; values differ per style
  task automatic t_xfer(input logic s);
    int n0;
    style <= s;
    n0 = wn;
    repeat (4) @(posedge ref_clk);
    u_fphp_host_model.access(1'b0, 1'b0, {s, 4'h3}, {s, 7'h25}, q);
    chk("wr_count", n0[7:0] + 8'h01, wn[7:0]);
    chk("wr_addr", {3'h0, s, 4'h3}, {3'h0, wa});
    chk("wr_data", {s, 7'h25}, wd);
    u_fphp_host_model.access(1'b0, 1'b1, s ? 5'h0c : 5'h1a, 8'h00, q);
    chk("rd_data", s ? 8'h65 : 8'hd5, q);
  endtask : t_xfer

  // Strobes with chip select high do nothing
  task automatic t_desel();
    int n0;
    n0 = wn;
    u_fphp_host_model.access(1'b1, 1'b0, 5'h01, 8'h3c, q);
    chk("desel_writes", n0[7:0], wn[7:0]);
    u_fphp_host_model.access(1'b1, 1'b1, 5'h01, 8'h3c, q);
    chk("desel_bus", ~8'h3c, q);
  endtask : t_desel

  // Interrupt while deselected, then reset pin
  task automatic t_irq_reset();
    irq_pending <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("irq_low", 8'h00, {7'h0, irq_line});
    irq_pending <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("irq_high", 8'h01, {7'h0, irq_line});
    fork
      u_fphp_host_model.pulse_reset();
      begin
        repeat (10) @(posedge ref_clk);
        chk("dev_reset", 8'h01, {7'h0, device_reset});
      end
    join
    chk("dev_run", 8'h00, {7'h0, device_reset});
  endtask : t_irq_reset

  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    u_fphp_host_model.pulse_reset();
    t_xfer(1'b1);
    t_xfer(1'b0);
    t_desel();
    t_irq_reset();
    summarize();
  end

  // Watchdog well beyond the expected run
  initial begin
    #100us;
    n_mismatch++;
    summarize();
  end
endmodule : fphp_top_tb
